// >>> sram_master.sv
`timescale 1ns/100ps
`default_nettype none
module sram_master (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // user command, one per clock
    input wire logic cmd_valid,
    input wire sram_bus_pkg::cmd_kind_t cmd_kind,
    input wire logic [sram_bus_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [sram_bus_pkg::LANES-1:0] cmd_lanes,
    input wire logic [sram_bus_pkg::DATA_W-1:0] cmd_wdata,
    input wire logic cmd_order,
    // user read answer
    output logic rd_valid,
    output logic [sram_bus_pkg::DATA_W-1:0] rd_data,
    // bus pins
    sram_bus_if.master bus
);
    // ----------------------------------------------------------------
    // pin registers
    // ----------------------------------------------------------------
    logic gate_n;                                    // presented gate
    sram_bus_pkg::cmd_kind_t pin_kind;               // presented kind
    logic [sram_bus_pkg::DATA_W-1:0] pin_wdata;      // data for that command
    logic [sram_bus_pkg::ADDR_W-1:0] addr;
    logic [sram_bus_pkg::LANES-1:0] lanes_n;
    logic order;
    logic dq_oe;
    logic [sram_bus_pkg::DATA_W-1:0] dq_out;
    logic oe_n;
    // device-side pending access, as tracked here
    logic acc_valid;
    logic acc_write;
    logic [sram_bus_pkg::DATA_W-1:0] due_data;

    // ----------------------------------------------------------------
    // decode of the presented command
    // ----------------------------------------------------------------
    wire taken = ~gate_n;
    wire pin_load = (pin_kind == sram_bus_pkg::kind_load_read)
        | (pin_kind == sram_bus_pkg::kind_load_write);
    wire next_acc_valid = taken ? (pin_load | ((pin_kind == sram_bus_pkg::kind_burst)
        & acc_valid)) : acc_valid;
    wire next_acc_write = taken ? (pin_load ? (pin_kind == sram_bus_pkg::kind_load_write)
        : acc_write) : acc_write;
    wire [sram_bus_pkg::DATA_W-1:0] next_due = taken ? pin_wdata : due_data;
    wire next_write_due = next_acc_valid & next_acc_write;
    wire read_due = acc_valid & ~acc_write;

    // ----------------------------------------------------------------
    // command pins, registered from the user side
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate_n <= 1'b1;
            pin_kind <= sram_bus_pkg::kind_deselect;
            pin_wdata <= sram_bus_pkg::DATA_RESET;
            addr <= sram_bus_pkg::ADDR_RESET;
            lanes_n <= sram_bus_pkg::LANES_OFF;
            order <= sram_bus_pkg::ORDER_LINEAR;
        end else begin
            gate_n <= ~cmd_valid;
            pin_kind <= cmd_kind;
            pin_wdata <= cmd_wdata;
            addr <= cmd_addr;
            lanes_n <= ~cmd_lanes;
            order <= cmd_order;
        end
    end

    // tracked access and data due in the next enabled cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acc_valid <= 1'b0;
            acc_write <= 1'b0;
            due_data <= sram_bus_pkg::DATA_RESET;
            dq_oe <= 1'b0;
            dq_out <= sram_bus_pkg::DATA_RESET;
            oe_n <= 1'b1;
        end else begin
            acc_valid <= next_acc_valid;
            acc_write <= next_acc_write;
            due_data <= next_due;
            dq_oe <= next_write_due & cmd_valid;
            dq_out <= next_due;
            oe_n <= next_write_due & cmd_valid;
        end
    end

    // read word sampled at the end of its enabled data cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data <= sram_bus_pkg::DATA_RESET;
        end else begin
            rd_valid <= taken & read_due;
            if (taken && read_due) begin
                rd_data <= bus.dq_level;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin mapping
    // ----------------------------------------------------------------
    wire pin_desel = (pin_kind == sram_bus_pkg::kind_deselect);
    assign bus.cycle_gate_n = gate_n;
    assign bus.address = addr;
    assign bus.read_write = (pin_kind != sram_bus_pkg::kind_load_write);
    assign bus.advance_or_load = (pin_kind == sram_bus_pkg::kind_burst);
    assign bus.select_low_a = pin_desel;
    assign bus.select_low_b_or_high = pin_desel;
    assign bus.select_high = ~pin_desel;
    assign bus.byte_write_sel_n = lanes_n;
    assign bus.output_enable_n = oe_n;
    assign bus.burst_order_drv = order;
    // interleaved order is left to the pin's pull-up
    assign bus.burst_order_oe = (order == sram_bus_pkg::ORDER_LINEAR);
    assign bus.m_dq_out = dq_out;
    assign bus.m_dq_oe = dq_oe;
endmodule // sram_master
`default_nettype wire

// >>> sram_bus_pkg.sv
`default_nettype none
package sram_bus_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;        // word address
    localparam int DATA_W = 36;        // data word
    localparam int LANES = 4;          // byte write lanes
    localparam int LANE_W = 9;         // bits per lane, parity included
    localparam int DEPTH = 131072;     // words
    localparam int BURST_W = 2;        // burst counter width
    // ----------------------------------------------------------------
    // reset values and burst step
    // ----------------------------------------------------------------
    localparam logic [BURST_W-1:0] COUNT_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
    localparam logic [LANES-1:0] LANES_OFF = 4'hF;
    localparam logic BURST_STEP = 1'b1;
    // ----------------------------------------------------------------
    // burst order values on the order pin
    // ----------------------------------------------------------------
    localparam logic ORDER_LINEAR = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;
    // master user command kinds
    typedef enum logic [1:0] {
        kind_load_read,
        kind_load_write,
        kind_burst,
        kind_deselect
    } cmd_kind_t;
endpackage
`default_nettype wire

// >>> sram_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sram_bus_if;
    // ----------------------------------------------------------------
    // pins driven by the master
    // ----------------------------------------------------------------
    logic [sram_bus_pkg::ADDR_W-1:0] address;      // word address
    logic read_write;                              // high read, low write
    logic advance_or_load;                         // low load, high advance
    logic select_low_a;                            // active low enable
    logic select_low_b_or_high;                    // active low enable
    logic select_high;                             // active high enable
    logic cycle_gate_n;                            // low: edge is used
    logic [sram_bus_pkg::LANES-1:0] byte_write_sel_n; // active low lanes
    logic output_enable_n;                         // async output gate
    logic burst_order_drv;                         // order pin value
    logic burst_order_oe;                          // master drives order pin
    // ----------------------------------------------------------------
    // shared data bus, one set per party
    // ----------------------------------------------------------------
    logic [sram_bus_pkg::DATA_W-1:0] m_dq_out;
    logic m_dq_oe;
    logic [sram_bus_pkg::DATA_W-1:0] s_dq_out;
    logic s_dq_oe;
    logic [sram_bus_pkg::DATA_W-1:0] dq_level;     // resolved wire
    logic burst_order_sel;                         // resolved order pin
    // released bus reads as zero, never as a stale word
    assign dq_level = s_dq_oe ? s_dq_out : (m_dq_oe ? m_dq_out : sram_bus_pkg::DATA_RESET);
    // undriven order pin is pulled high
    assign burst_order_sel = burst_order_oe ? burst_order_drv : sram_bus_pkg::ORDER_INTERLEAVED;

    modport device (
        input address, read_write, advance_or_load, select_low_a,
        input select_low_b_or_high, select_high, cycle_gate_n,
        input byte_write_sel_n, output_enable_n, burst_order_sel, dq_level,
        output s_dq_out, s_dq_oe
    );
    modport master (
        output address, read_write, advance_or_load, select_low_a,
        output select_low_b_or_high, select_high, cycle_gate_n,
        output byte_write_sel_n, output_enable_n, burst_order_drv, burst_order_oe,
        output m_dq_out, m_dq_oe,
        input dq_level
    );
endinterface
`default_nettype wire

// >>> sram_device.sv
`timescale 1ns/100ps
`default_nettype none
module sram_device (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // bus pins
    sram_bus_if.device bus
);
    // ----------------------------------------------------------------
    // storage and pending access
    // ----------------------------------------------------------------
    logic [sram_bus_pkg::DATA_W-1:0] mem [sram_bus_pkg::DEPTH]; // array
    logic pend_valid;                                  // data cycle due
    logic pend_write;                                  // due cycle is write
    logic [sram_bus_pkg::ADDR_W-1:0] base_addr;        // loaded address
    logic [sram_bus_pkg::BURST_W-1:0] count;           // burst count
    logic order;                                       // order of burst
    logic [sram_bus_pkg::LANES-1:0] pend_lanes_n;      // lanes of due write
    logic [sram_bus_pkg::DATA_W-1:0] read_word;        // flow-through word
    logic read_valid;                                  // word held for bus

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire enabled = ~bus.cycle_gate_n;
    wire selected = ~bus.select_low_a & ~bus.select_low_b_or_high
        & bus.select_high;
    wire is_load = ~bus.advance_or_load & selected;
    wire is_deselect = ~bus.advance_or_load & ~selected;
    wire is_advance = bus.advance_or_load & pend_valid;
    // current effective address of the due data cycle
    wire [sram_bus_pkg::BURST_W-1:0] low_lin = base_addr[1:0] + count;
    wire [sram_bus_pkg::BURST_W-1:0] low_ilv = base_addr[1:0] ^ count;
    wire [sram_bus_pkg::ADDR_W-1:0] cur_addr = {base_addr[sram_bus_pkg::ADDR_W-1:2],
        (order == sram_bus_pkg::ORDER_LINEAR) ? low_lin : low_ilv};
    // count wraps naturally after the fourth beat
    wire [sram_bus_pkg::BURST_W-1:0] count_step = count + {1'b0, sram_bus_pkg::BURST_STEP};
    wire [sram_bus_pkg::BURST_W-1:0] adv_lin = base_addr[1:0] + count_step;
    wire [sram_bus_pkg::BURST_W-1:0] adv_ilv = base_addr[1:0] ^ count_step;
    // ----------------------------------------------------------------
    // next state of the pending access
    // ----------------------------------------------------------------
    wire next_valid = is_load | is_advance;
    wire next_write = is_load ? ~bus.read_write : pend_write;
    wire [sram_bus_pkg::ADDR_W-1:0] next_addr = is_load ? bus.address
        : {base_addr[sram_bus_pkg::ADDR_W-1:2],
           (order == sram_bus_pkg::ORDER_LINEAR) ? adv_lin : adv_ilv};
    wire write_now = enabled & pend_valid & pend_write;
    // ----------------------------------------------------------------
    // write lanes, also merged into a read of the same word
    // ----------------------------------------------------------------
    logic [sram_bus_pkg::DATA_W-1:0] merged;       // word after this write
    logic [sram_bus_pkg::DATA_W-1:0] stored;       // word at next address
    logic [sram_bus_pkg::DATA_W-1:0] current;      // word at due address
    logic [sram_bus_pkg::DATA_W-1:0] write_word;   // due word, lanes applied
    assign stored = mem[next_addr];
    assign current = mem[cur_addr];
    genvar lane;
    generate
        for (lane = 0; lane < sram_bus_pkg::LANES; lane++) begin : g_lane
            localparam int LO = lane * sram_bus_pkg::LANE_W;
            // forward a byte written this edge to a read of the same word
            wire hit = write_now & ~pend_lanes_n[lane] & (cur_addr == next_addr);
            assign merged[LO +: sram_bus_pkg::LANE_W] = hit
                ? bus.dq_level[LO +: sram_bus_pkg::LANE_W]
                : stored[LO +: sram_bus_pkg::LANE_W];
            // lane write, data taken in first enabled cycle after command
            assign write_word[LO +: sram_bus_pkg::LANE_W] = pend_lanes_n[lane]
                ? current[LO +: sram_bus_pkg::LANE_W]
                : bus.dq_level[LO +: sram_bus_pkg::LANE_W];
        end
    endgenerate

    // one writer for the whole array; unselected lanes keep their contents
    always_ff @(posedge clock) begin
        if (write_now) begin
            mem[cur_addr] <= write_word;
        end
    end

    // ----------------------------------------------------------------
    // access pipeline
    // ----------------------------------------------------------------
    // pending access advances only on enabled edges
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pend_valid <= 1'b0;
            pend_write <= 1'b0;
            base_addr <= sram_bus_pkg::ADDR_RESET;
            count <= sram_bus_pkg::COUNT_RESET;
            order <= sram_bus_pkg::ORDER_INTERLEAVED;
            pend_lanes_n <= sram_bus_pkg::LANES_OFF;
        end else if (enabled) begin
            pend_valid <= next_valid & ~is_deselect;
            pend_write <= next_write;
            pend_lanes_n <= bus.byte_write_sel_n;
            if (is_load) begin
                base_addr <= bus.address;
                count <= sram_bus_pkg::COUNT_RESET;
                order <= bus.burst_order_sel;
            end else if (is_advance) begin
                count <= count_step;
            end
        end
    end

    // flow-through read word, held while edges are gated
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            read_valid <= 1'b0;
            read_word <= sram_bus_pkg::DATA_RESET;
        end else if (enabled) begin
            read_valid <= next_valid & ~next_write & ~is_deselect;
            read_word <= merged;
        end
    end

    // ----------------------------------------------------------------
    // data bus drive; output enable acts without the clock
    // ----------------------------------------------------------------
    assign bus.s_dq_out = read_word;
    assign bus.s_dq_oe = read_valid & ~bus.output_enable_n;
endmodule // sram_device
`default_nettype wire

// >>> sram_bus_props.sv
`timescale 1ns/100ps
`default_nettype none
module sram_bus_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // master control pins
    input wire logic read_write,
    input wire logic advance_or_load,
    input wire logic select_low_a,
    input wire logic select_low_b_or_high,
    input wire logic select_high,
    input wire logic cycle_gate_n,
    input wire logic [sram_bus_pkg::LANES-1:0] byte_write_sel_n,
    input wire logic output_enable_n,
    // data bus drives
    input wire logic m_dq_oe,
    input wire logic [sram_bus_pkg::DATA_W-1:0] s_dq_out,
    input wire logic s_dq_oe
);
    // ----------------------------------------------------------------
    // cycle decode
    // ----------------------------------------------------------------
    wire logic sel_on = !select_low_a && !select_low_b_or_high && select_high; // composite select
    wire logic go = !cycle_gate_n;                                  // edge is used
    wire logic load_rd = go && !advance_or_load && sel_on && read_write;  // read load
    wire logic load_wr = go && !advance_or_load && sel_on && !read_write; // write load
    wire logic desel = go && !advance_or_load && !sel_on;           // deselect cycle
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------------------------------
    // device side
    // ----------------------------------------------------------------
    float_at_start_a: assert property ($rose(rst_b) |-> !s_dq_oe)
        else $error("data bus driven right after reset");
    deselect_floats_a: assert property (desel |=> !s_dq_oe)
        else $error("data bus driven after a deselect cycle");
    write_floats_a: assert property (load_wr |=> !s_dq_oe)
        else $error("device drives bus in a write data cycle");
    read_answers_a: assert property (load_rd ##1 go |-> s_dq_oe && !output_enable_n)
        else $error("no read data in the cycle after a read load");
    deselect_completes_a: assert property (load_rd ##1 desel |-> s_dq_oe)
        else $error("pending read not driven in deselect cycle");
    gated_hold_a: assert property (cycle_gate_n |=> $stable(s_dq_out))
        else $error("read word changed on a gated edge");
    gated_keeps_drive_a: assert property (cycle_gate_n && s_dq_oe |=>
        s_dq_oe || output_enable_n)
        else $error("read word dropped during suspended cycle");
    burst_continues_a: assert property (go && advance_or_load && s_dq_oe |=>
        s_dq_oe || output_enable_n)
        else $error("read burst beat missing after advance");
    // ----------------------------------------------------------------
    // master side
    // ----------------------------------------------------------------
    write_data_drive_a: assert property (load_wr ##1 go |-> m_dq_oe && output_enable_n)
        else $error("master not driving write data in data cycle");
    no_contention_a: assert property (m_dq_oe |-> !s_dq_oe)
        else $error("both parties drive the data bus");
    write_lanes_a: assert property (load_wr |-> byte_write_sel_n != sram_bus_pkg::LANES_OFF)
        else $error("write load with no byte lane selected");
    // main scenarios seen
    cover property (load_rd ##1 go ##0 s_dq_oe);
    cover property (cycle_gate_n && s_dq_oe);
    cover property (load_wr ##1 go ##0 m_dq_oe);
endmodule // sram_bus_props
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ----------------------------------------------------------------
    // stimulus and bookkeeping
    // ----------------------------------------------------------------
    localparam int AW = sram_bus_pkg::ADDR_W;
    localparam int DW = sram_bus_pkg::DATA_W;
    localparam int LW = sram_bus_pkg::LANE_W;
    localparam sram_bus_pkg::cmd_kind_t RD = sram_bus_pkg::kind_load_read;
    localparam sram_bus_pkg::cmd_kind_t WR = sram_bus_pkg::kind_load_write;
    localparam sram_bus_pkg::cmd_kind_t BU = sram_bus_pkg::kind_burst;
    localparam sram_bus_pkg::cmd_kind_t DS = sram_bus_pkg::kind_deselect;
    localparam logic LIN = sram_bus_pkg::ORDER_LINEAR;
    localparam logic ILV = sram_bus_pkg::ORDER_INTERLEAVED;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    sram_bus_pkg::cmd_kind_t cmd_kind = DS;
    logic [AW-1:0] cmd_addr = '0;
    logic [sram_bus_pkg::LANES-1:0] cmd_lanes = '0;
    logic [DW-1:0] cmd_wdata = '0;
    logic cmd_order = LIN;
    logic rd_valid;
    logic [DW-1:0] rd_data;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [DW-1:0] mem [logic [AW-1:0]]; // reference memory
    logic [DW-1:0] expect_q [$];         // read words still owed
    logic [AW-1:0] base;                 // loaded start address
    logic [1:0] step;                    // beat count, wraps at four
    logic live = 1'b0;                   // access in progress
    logic reading = 1'b0;
    logic mode = LIN;
    always #12.5 clock = ~clock;
    // ----------------------------------------------------------------
    // the two ends facing each other
    // ----------------------------------------------------------------
    sram_bus_if bus_link();
    sram_device sram_device_i (.clock(clock), .rst_b(rst_b), .bus(bus_link.device));
    sram_master sram_master_i (.clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_lanes(cmd_lanes),
        .cmd_wdata(cmd_wdata), .cmd_order(cmd_order), .rd_valid(rd_valid),
        .rd_data(rd_data), .bus(bus_link.master));
    sram_bus_props sram_bus_props_i (.clock(clock), .rst_b(rst_b),
        .read_write(bus_link.read_write), .advance_or_load(bus_link.advance_or_load),
        .select_low_a(bus_link.select_low_a), .select_low_b_or_high(bus_link.select_low_b_or_high),
        .select_high(bus_link.select_high), .cycle_gate_n(bus_link.cycle_gate_n),
        .byte_write_sel_n(bus_link.byte_write_sel_n), .output_enable_n(bus_link.output_enable_n),
        .m_dq_oe(bus_link.m_dq_oe), .s_dq_out(bus_link.s_dq_out), .s_dq_oe(bus_link.s_dq_oe));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [DW-1:0] pat(input int n);
        return 36'h9A5C3E000 ^ (36'h0F0F1E2D3 * DW'(n + 1));
    endfunction
    task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one user command per clock; reference tracks beats and addresses
    task automatic issue(input sram_bus_pkg::cmd_kind_t kind, input logic [AW-1:0] addr,
            input logic [sram_bus_pkg::LANES-1:0] lanes, input int n, input logic order);
        logic [AW-1:0] at;
        logic [DW-1:0] word;
        logic [DW-1:0] wd;
        wd = pat(n);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_kind <= kind;
        cmd_addr <= addr;
        cmd_lanes <= lanes;
        cmd_wdata <= wd;
        cmd_order <= order;
        if (kind == RD || kind == WR) begin
            base = addr;
            step = 2'h0;
            live = 1'b1;
            reading = (kind == RD);
            mode = order;
        end else if (kind == BU) begin
            step = step + 2'h1;
        end else begin
            live = 1'b0;
        end
        at = {base[AW-1:2], (mode ? base[1:0] ^ step : base[1:0] + step)};
        if (live) begin
            word = mem.exists(at) ? mem[at] : '0;
            if (reading) begin
                expect_q.push_back(word);
            end else begin
                for (int k = 0; k < sram_bus_pkg::LANES; k++) begin
                    if (lanes[k]) word[k*LW +: LW] = wd[k*LW +: LW];
                end
                mem[at] = word;
            end
        end
    endtask
    // suspended cycles: gate held high
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            cmd_valid <= 1'b0;
        end
    endtask
    // every returned read word against the reference, in order
    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            if (expect_q.size() > 0) begin
                check(rd_data, expect_q.pop_front());
            end else begin
                // a read word that no command asked for
                check(DW'(expect_q.size()), DW'(1));
            end
        end
    end
    // ----------------------------------------------------------------
    // verdict and hang guard
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        check(DW'(bus_link.s_dq_oe), '0);
        // five beat linear write burst, last beat wraps onto the first
        issue(WR, 17'h00011, 4'hF, 0, LIN);
        for (int i = 1; i < 5; i++) begin
            issue(BU, '0, 4'hF, i, LIN);
        end
        // interleaved read burst straight after the last write beat
        issue(RD, 17'h00012, 4'h0, 0, ILV);
        for (int i = 0; i < 4; i++) begin
            issue(BU, '0, 4'h0, 0, ILV);
        end
        // back-to-back partial lane writes, then reads of the same words
        issue(WR, 17'h00011, 4'h5, 10, LIN);
        issue(WR, 17'h00013, 4'hA, 11, LIN);
        issue(RD, 17'h00013, 4'h0, 0, LIN);
        issue(RD, 17'h00011, 4'h0, 0, LIN);
        // suspended cycles after a read load and after a write load
        issue(RD, 17'h00012, 4'h0, 0, LIN);
        idle(3);
        issue(WR, 17'h1FFE0, 4'hF, 20, LIN);
        idle(2);
        issue(RD, 17'h1FFE0, 4'h0, 0, LIN);
        // deselect finishes pending work; advance after it is refused
        issue(DS, '0, 4'h0, 0, LIN);
        issue(BU, '0, 4'h0, 0, LIN);
        issue(WR, 17'h00021, 4'hF, 30, LIN);
        issue(DS, '0, 4'h0, 31, LIN);
        issue(RD, 17'h00021, 4'h0, 0, LIN);
        issue(DS, '0, 4'h0, 0, LIN);
        issue(DS, '0, 4'h0, 0, LIN);
        idle(6);
        check(DW'(expect_q.size()), '0);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
